// ==== pkg/csp_consts.svh ====
// Constants shared by the clock supervision block: timing and reset values.
// Assumes a single 100 MHz system clock; included by its bare name.
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

// System clock period in nanoseconds.
`define CSP_CLK_PERIOD_NS 10
// Silence on the main oscillator, in nanoseconds, that counts as a stop.
`define CSP_OSD_TIMEOUT_NS 1000
// Cycles of silence, rounded down so detection is never late.
`define CSP_OSD_CYCLES (`CSP_OSD_TIMEOUT_NS / `CSP_CLK_PERIOD_NS)
// Reset value of the clock divider.
`define CSP_RST_DIV 3'h0
// Default width of the frequency checker edge counter.
`define CSP_CNT_W 16

`endif

// ==== pkg/csp_pkg.sv ====
// Types of the clock supervision block: modes, sources and checker states.
// Assumes nothing beyond a SystemVerilog compiler.
package csp_pkg;

    // Operating power control modes, fastest first.
    typedef enum logic [2:0] {
        CSP_MODE_HIGH = 3'h0,
        CSP_MODE_MID_A = 3'h1,
        CSP_MODE_MID_B = 3'h2,
        CSP_MODE_LOW_A = 3'h3,
        CSP_MODE_LOW_B = 3'h4
    } csp_mode_t;

    // Clock sources that the system clock can be taken from.
    typedef enum logic [1:0] {
        CSP_SRC_MAIN = 2'h0,
        CSP_SRC_SUB = 2'h1,
        CSP_SRC_LS_ONCHIP = 2'h2,
        CSP_SRC_PLL = 2'h3
    } csp_src_t;

    // Reference selection of the frequency accuracy checker.
    typedef enum logic {
        CSP_REF_EXT = 1'b0,
        CSP_REF_INT = 1'b1
    } csp_ref_t;

    // Measurement sequencer states.
    typedef enum logic [1:0] {
        CSP_ST_IDLE = 2'h0,
        CSP_ST_ARM = 2'h1,
        CSP_ST_COUNT = 2'h2
    } csp_state_t;

endpackage

// ==== pkg/csp_meas_if.sv ====
// Link between the supervision top and its frequency accuracy checker.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface csp_meas_if #(parameter int CNT_W = 16);
    import csp_pkg::*;
    logic en;
    csp_src_t mon_sel;
    csp_ref_t ref_sel;
    csp_src_t ref_int_sel;
    logic [CNT_W-1:0] lim_hi;
    logic [CNT_W-1:0] lim_lo;
    logic done;
    logic range_err;
    logic [CNT_W-1:0] count;

    // Control side sets up a measurement and collects the results.
    modport ctl (
        output en, mon_sel, ref_sel, ref_int_sel, lim_hi, lim_lo,
        input done, range_err, count
    );
    // Checker side performs the measurement.
    modport chk (
        input en, mon_sel, ref_sel, ref_int_sel, lim_hi, lim_lo,
        output done, range_err, count
    );
endinterface

// ==== core/csp_freq_checker.sv ====
// Frequency accuracy checker: counts monitored clock edges per reference
// period. Assumes clock levels arrive synchronous to ref_clk.
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_freq_checker
    import csp_pkg::*;
#(
    parameter int CNT_W = `CSP_CNT_W
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Oscillator levels, indexed by source code, and the external pin.
    input wire logic [3:0] osc_lvl,
    input wire logic ref_pin,
    // Link to the controlling top.
    csp_meas_if.chk m
);

    generate
        if (CNT_W < 4 || CNT_W > 32) begin : g_bad_width
            $error("csp_freq_checker: CNT_W must be 4 to 32");
        end
    endgenerate

    csp_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] res_q, res_d;
    logic done_q, done_d;
    logic err_q, err_d;
    logic [3:0] lvl_q;
    logic pin_q;
    logic [3:0] rise;
    logic mon_rise;
    logic ref_rise;
    logic [CNT_W-1:0] final_cnt;

    // Edge detection on every clock level and on the reference pin.
    assign rise = osc_lvl & ~lvl_q;
    assign mon_rise = rise[m.mon_sel];
    assign ref_rise = (m.ref_sel == CSP_REF_EXT) ? (ref_pin & ~pin_q)
                                                 : rise[m.ref_int_sel];
    // Count saturates so a runaway clock still reads as too fast.
    assign final_cnt = (mon_rise && cnt_q != {CNT_W{1'b1}}) ?
                       cnt_q + 1'b1 : cnt_q;

    // Window sequencer: a window is one reference period, back to back.
    // A reference that stops stalls the window; no result is produced.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        res_d = res_q;
        done_d = 1'b0;
        err_d = 1'b0;
        unique case (st_q)
            CSP_ST_IDLE: begin
                if (m.en) begin
                    st_d = CSP_ST_ARM;
                end
            end
            CSP_ST_ARM: begin
                if (!m.en) begin
                    st_d = CSP_ST_IDLE;
                end else if (ref_rise) begin
                    st_d = CSP_ST_COUNT;
                    cnt_d = '0;
                end
            end
            CSP_ST_COUNT: begin
                cnt_d = final_cnt;
                if (!m.en) begin
                    st_d = CSP_ST_IDLE;
                end else if (ref_rise) begin
                    res_d = final_cnt;
                    done_d = 1'b1;
                    // A stopped clock counts zero and falls below the
                    // lower limit.
                    err_d = (final_cnt > m.lim_hi) ||
                            (final_cnt < m.lim_lo);
                    cnt_d = '0;
                end
            end
            default: begin
                st_d = CSP_ST_IDLE;
            end
        endcase
    end

    // State registers of the sequencer and edge detectors.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= CSP_ST_IDLE;
            cnt_q <= '0;
            res_q <= '0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            lvl_q <= 4'h0;
            pin_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            res_q <= res_d;
            done_q <= done_d;
            err_q <= err_d;
            lvl_q <= osc_lvl;
            pin_q <= ref_pin;
        end
    end

    assign m.done = done_q;
    assign m.range_err = err_q;
    assign m.count = res_q;

endmodule

// ==== core/csp_top.sv ====
// Clock supervision and power mode control: mode ordering, frequency
// accuracy checking and oscillation stop fallback. Assumes oscillator
// levels are synchronous to ref_clk and control strobes are one cycle.
//
// Overview of operation
// - One high, two middle and two low modes with own voltage and limits.
// - Checker measures a clock against external pin or internal clock.
// - Checker flags measurement end and, separately, out of range frequency.
// - Stopped sub-clock measured by on-chip oscillator reads as out of range.
// - Main clock stopping while selected switches to the low-speed oscillator.
// - Stop while sub, on-chip or PLL is selected leaves selection alone.
// - PLL left selected after its input stops runs at self-oscillation.
`timescale 1ns/1ps
`include "csp_consts.svh"
module csp_top
    import csp_pkg::*;
#(
    parameter int CNT_W = `CSP_CNT_W,
    parameter int OSD_CYCLES = `CSP_OSD_CYCLES,
    parameter logic [23:0] MAIN_KHZ = 24'h004e20,
    parameter logic [23:0] SUB_KHZ = 24'h000020,
    parameter logic [23:0] LS_ONCHIP_KHZ = 24'h0000f0,
    parameter logic [23:0] PLL_KHZ = 24'h01d4c0,
    parameter logic [23:0] LIM_HIGH_KHZ = 24'h01d4c0,
    parameter logic [23:0] LIM_MID_KHZ = 24'h0061a8,
    parameter logic [23:0] LIM_LOW_KHZ = 24'h0000f0
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Oscillator levels and external reference pin.
    input wire logic main_osc,
    input wire logic sub_osc,
    input wire logic low_speed_onchip_osc,
    input wire logic pll_osc,
    input wire logic ref_pin,
    // Power mode and clock change requests.
    input wire csp_mode_t mode_in,
    input wire logic mode_wr,
    input wire csp_src_t src_in,
    input wire logic [2:0] div_in,
    input wire logic clk_wr,
    // Current selection and supply level.
    output csp_mode_t mode_q,
    output csp_src_t src_q,
    output logic [2:0] div_q,
    output logic [1:0] volt_level_q,
    output logic pll_free_run,
    // Refused change reporting.
    output logic order_err,
    input wire logic order_err_clr,
    // Frequency accuracy checker setup.
    input wire logic meas_en,
    input wire csp_src_t mon_sel,
    input wire csp_ref_t ref_sel,
    input wire csp_src_t ref_int_sel,
    input wire logic [CNT_W-1:0] lim_hi,
    input wire logic [CNT_W-1:0] lim_lo,
    // Frequency accuracy checker results.
    output logic [CNT_W-1:0] meas_count,
    output logic meas_done_flag,
    output logic range_err_flag,
    input wire logic meas_done_clr,
    input wire logic range_err_clr,
    input wire logic meas_done_ie,
    input wire logic range_err_ie,
    output logic meas_irq,
    output logic range_irq,
    // Oscillation stop detection.
    input wire logic osd_en,
    output logic osd_flag,
    input wire logic osd_clr,
    input wire logic osd_ie,
    output logic osd_irq
);

    generate
        if (OSD_CYCLES < 2 || OSD_CYCLES > 65535) begin : g_bad_osd
            $error("csp_top: OSD_CYCLES must be 2 to 65535");
        end
    endgenerate

    localparam logic [15:0] OSD_LAST = 16'(OSD_CYCLES - 1);

    // Nominal frequency of a source after the divider.
    function automatic logic [23:0] freq_khz(csp_src_t s, logic [2:0] d);
        logic [23:0] f;
        f = MAIN_KHZ;
        unique case (s)
            CSP_SRC_MAIN: f = MAIN_KHZ;
            CSP_SRC_SUB: f = SUB_KHZ;
            CSP_SRC_LS_ONCHIP: f = LS_ONCHIP_KHZ;
            CSP_SRC_PLL: f = PLL_KHZ;
        endcase
        return f >> d;
    endfunction

    // Highest frequency a mode allows; an illegal code allows nothing.
    function automatic logic [23:0] mode_limit(csp_mode_t md);
        logic [23:0] l;
        l = 24'h000000;
        case (md)
            CSP_MODE_HIGH: l = LIM_HIGH_KHZ;
            CSP_MODE_MID_A, CSP_MODE_MID_B: l = LIM_MID_KHZ;
            CSP_MODE_LOW_A, CSP_MODE_LOW_B: l = LIM_LOW_KHZ;
            default: l = 24'h000000;
        endcase
        return l;
    endfunction

    // Supply level each mode demands, higher for faster modes.
    function automatic logic [1:0] mode_volt(csp_mode_t md);
        logic [1:0] v;
        v = 2'h2;
        case (md)
            CSP_MODE_HIGH: v = 2'h2;
            CSP_MODE_MID_A, CSP_MODE_MID_B: v = 2'h1;
            default: v = 2'h0;
        endcase
        return v;
    endfunction

    csp_meas_if #(.CNT_W(CNT_W)) meas ();

    logic main_prev_q;
    logic [15:0] stall_q, stall_d;
    logic main_stop_q, main_stop_d;
    logic osd_evt;
    csp_mode_t mode_d;
    csp_src_t src_d;
    logic [2:0] div_d;
    logic [1:0] volt_d;
    logic err_q, err_d;
    logic osdf_q, osdf_d;
    logic donef_q, donef_d;
    logic rngf_q, rngf_d;

    // Silence watchdog on the main oscillator; any edge restarts it.
    always_comb begin
        stall_d = stall_q;
        main_stop_d = main_stop_q;
        osd_evt = 1'b0;
        if (main_osc != main_prev_q) begin
            stall_d = 16'h0000;
            main_stop_d = 1'b0;
        end else if (stall_q != OSD_LAST) begin
            stall_d = stall_q + 16'h0001;
        end else if (!main_stop_q) begin
            main_stop_d = 1'b1;
            osd_evt = osd_en;
        end
    end

    // Mode and clock selection. Each request is refused when, against the other's
    // current value, it would leave the clock above the mode's limit, so a wrong order
    // over separate cycles shows up as a refusal instead of an overclocked core.
    always_comb begin
        mode_d = mode_q;
        src_d = src_q;
        div_d = div_q;
        err_d = err_q & ~order_err_clr;
        if (mode_wr) begin
            if (freq_khz(src_q, div_q) <= mode_limit(mode_in)) begin
                mode_d = mode_in;
            end else begin
                err_d = 1'b1;
            end
        end
        if (clk_wr) begin
            if (freq_khz(src_in, div_in) <= mode_limit(mode_q) &&
                !(src_in == CSP_SRC_MAIN && main_stop_q)) begin
                src_d = src_in;
                div_d = div_in;
            end else begin
                err_d = 1'b1;
            end
        end
        // Fallback overrides a source change requested in the same cycle; a divider change still applies.
        if (osd_evt && src_q == CSP_SRC_MAIN) begin
            src_d = CSP_SRC_LS_ONCHIP;
        end
        // Other sources stay selected when the main clock stops.
        volt_d = mode_volt(mode_d);
    end

    // Sticky event flags; a new event wins over a clear.
    always_comb begin
        osdf_d = osd_evt | (osdf_q & ~osd_clr);
        donef_d = meas.done | (donef_q & ~meas_done_clr);
        rngf_d = meas.range_err | (rngf_q & ~range_err_clr);
    end

    // Registers of all control state.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            main_prev_q <= 1'b0;
            stall_q <= 16'h0000;
            main_stop_q <= 1'b0;
            mode_q <= CSP_MODE_HIGH;
            src_q <= CSP_SRC_LS_ONCHIP;
            div_q <= `CSP_RST_DIV;
            volt_level_q <= 2'h2;
            err_q <= 1'b0;
            osdf_q <= 1'b0;
            donef_q <= 1'b0;
            rngf_q <= 1'b0;
        end else begin
            main_prev_q <= main_osc;
            stall_q <= stall_d;
            main_stop_q <= main_stop_d;
            mode_q <= mode_d;
            src_q <= src_d;
            div_q <= div_d;
            volt_level_q <= volt_d;
            err_q <= err_d;
            osdf_q <= osdf_d;
            donef_q <= donef_d;
            rngf_q <= rngf_d;
        end
    end

    // The PLL keeps running unlocked while its input is silent.
    assign pll_free_run = (src_q == CSP_SRC_PLL) && main_stop_q;

    // Checker setup passes straight from the ports.
    assign meas.en = meas_en;
    assign meas.mon_sel = mon_sel;
    assign meas.ref_sel = ref_sel;
    assign meas.ref_int_sel = ref_int_sel;
    assign meas.lim_hi = lim_hi;
    assign meas.lim_lo = lim_lo;

    csp_freq_checker #(.CNT_W(CNT_W)) u_chk (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .osc_lvl({pll_osc, low_speed_onchip_osc, sub_osc, main_osc}),
        .ref_pin(ref_pin),
        .m(meas)
    );

    // Results and gated interrupt requests.
    assign meas_count = meas.count;
    assign order_err = err_q;
    assign osd_flag = osdf_q;
    assign meas_done_flag = donef_q;
    assign range_err_flag = rngf_q;
    assign osd_irq = osdf_q & osd_ie;
    assign meas_irq = donef_q & meas_done_ie;
    assign range_irq = rngf_q & range_err_ie;

endmodule

// ==== tb/csp_osc_model.sv ====
// Oscillator and reference pin model for the clock supervision block.
// Assumes levels change on the falling edge of the system clock.
`timescale 1ns/1ps
module csp_osc_model (
    // System clock and stop controls.
    input wire logic ref_clk,
    input wire logic main_run,
    input wire logic sub_run,
    // Oscillator levels and the external reference pin.
    output logic main_osc,
    output logic sub_osc,
    output logic low_speed_onchip_osc,
    output logic pll_osc,
    output logic ref_pin
);
    logic [4:0] cnt_q = 5'h00;

    initial {main_osc, sub_osc, low_speed_onchip_osc, pll_osc, ref_pin} = 5'h00;

    // A stopped source freezes, as a dead crystal does, so edges vanish.
    always @(negedge ref_clk) begin
        cnt_q <= cnt_q + 5'h01;
        pll_osc <= ~pll_osc;
        if (main_run)
            main_osc <= ~main_osc;
        if (sub_run && cnt_q[1:0] == 2'h0)
            sub_osc <= ~sub_osc;
        if (cnt_q[3:0] == 4'h0)
            low_speed_onchip_osc <= ~low_speed_onchip_osc;
        if (cnt_q == 5'h00)
            ref_pin <= ~ref_pin;
    end
endmodule

// ==== tb/csp_top_properties.sv ====
// Timing relations of the clock supervision top, seen at its ports.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module csp_top_properties
    import csp_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Mode and clock selection.
    input wire csp_mode_t mode_in,
    input wire logic mode_wr,
    input wire logic clk_wr,
    input wire csp_mode_t mode_q,
    input wire csp_src_t src_q,
    input wire logic [2:0] div_q,
    input wire logic [1:0] volt_level_q,
    input wire logic pll_free_run,
    input wire logic order_err,
    // Flags, enables and interrupt lines.
    input wire logic meas_done_flag,
    input wire logic range_err_flag,
    input wire logic meas_done_ie,
    input wire logic range_err_ie,
    input wire logic meas_irq,
    input wire logic range_irq,
    input wire logic osd_flag,
    input wire logic osd_clr,
    input wire logic osd_ie,
    input wire logic osd_irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // Interrupt lines are plain gates of flag and enable.
    a_meas_irq_gate:
        assert property (meas_irq == (meas_done_flag && meas_done_ie))
        else $error("measure interrupt disagrees with its flag");
    a_range_irq_gate:
        assert property (range_irq == (range_err_flag && range_err_ie))
        else $error("range interrupt disagrees with its flag");
    a_osd_irq_gate:
        assert property (osd_irq == (osd_flag && osd_ie))
        else $error("stop interrupt disagrees with its flag");
    // The stop flag holds until software clears it.
    a_osd_flag_sticky:
        assert property (osd_flag && !osd_clr |=> osd_flag)
        else $error("stop flag dropped without a clear");
    // Fallback to the slow oscillator only when main was selected.
    a_fallback_main:
        assert property ($rose(osd_flag) && $past(src_q) == CSP_SRC_MAIN
            |-> src_q == CSP_SRC_LS_ONCHIP)
        else $error("main stop did not fall back");
    a_keep_source:
        assert property ($rose(osd_flag) && $past(src_q) != CSP_SRC_MAIN
            && !$past(clk_wr) |-> $stable(src_q))
        else $error("stop moved a non-main selection");
    a_pll_free_run:
        assert property (pll_free_run |-> src_q == CSP_SRC_PLL)
        else $error("free run shown without the pll selected");
    a_volt_by_mode:
        assert property (volt_level_q == ((mode_q == CSP_MODE_HIGH) ? 2'h2
            : (mode_q inside {CSP_MODE_MID_A, CSP_MODE_MID_B}) ? 2'h1 : 2'h0))
        else $error("supply level does not match mode");
    // Dropping to low mode while main clocks the core must be refused;
    // only the deepest divider brings main under the low mode limit.
    a_slow_refused:
        assert property (mode_wr && mode_in == CSP_MODE_LOW_A
            && src_q == CSP_SRC_MAIN && div_q < 3'h7
            |=> order_err && $stable(mode_q))
        else $error("slowing the mode before the clock was taken");
endmodule

bind csp_top csp_top_properties i_props (.*);

// ==== tb/csp_top_bench.sv ====
// Self-checking bench for the clock supervision top: mode ordering, stop
// fallback and frequency checks. Assumes the oscillator model in tb/.
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("wrong value at %0t: got %h want %h", $time, got, exp); \
        end \
    end
module csp_top_bench;
    import csp_pkg::*;
    localparam int OSD = 8;
    localparam csp_src_t SRC_LS = CSP_SRC_LS_ONCHIP;
    logic ref_clk = 1'b0, rstn = 1'b0, main_run = 1'b1, sub_run = 1'b1;
    logic main_osc, sub_osc, low_speed_onchip_osc, pll_osc, ref_pin;
    csp_mode_t mode_in = CSP_MODE_HIGH, mode_q;
    csp_src_t src_in = SRC_LS, mon_sel = CSP_SRC_MAIN, src_q;
    csp_src_t ref_int_sel = SRC_LS;
    csp_ref_t ref_sel = CSP_REF_EXT;
    logic [2:0] div_in = 3'h0, div_q, d;
    logic [1:0] volt_level_q;
    logic [15:0] lim_hi = 16'h0000, lim_lo = 16'h0000, meas_count;
    logic [31:0] obs;
    logic mode_wr = 1'b0, clk_wr = 1'b0, order_err_clr = 1'b0;
    logic meas_en = 1'b0, meas_done_clr = 1'b0, range_err_clr = 1'b0;
    logic osd_en = 1'b1, osd_ie = 1'b1, osd_clr = 1'b0;
    logic meas_done_ie = 1'b1, range_err_ie = 1'b1;
    logic pll_free_run, order_err, meas_done_flag, range_err_flag;
    logic meas_irq, range_irq, osd_flag, osd_irq;
    logic [63:0] notes[$];
    logic [63:0] n;
    int miscompares = 0;
    int total_checks = 0;
    integer seed = 32'h4539;
    event look;

    csp_osc_model i_osc (.ref_clk(ref_clk), .main_run(main_run),
        .sub_run(sub_run), .main_osc(main_osc), .sub_osc(sub_osc),
        .low_speed_onchip_osc(low_speed_onchip_osc), .pll_osc(pll_osc),
        .ref_pin(ref_pin));
    csp_top #(.OSD_CYCLES(OSD)) i_dut (.*);

    // Window count in the upper half, selection and flags in the lower.
    assign obs = {meas_count, mode_q, src_q, div_q, volt_level_q, order_err,
        pll_free_run, osd_flag, osd_irq, meas_done_flag, range_err_flag};

    // Free-running 100 MHz clock.
    initial forever #5 ref_clk = ~ref_clk;

    // Each note taken off the queue is compared with the current observation.
    always @(look) begin
        n = notes.pop_front();
        `CHK(obs & n[63:32], n[31:0] & n[63:32])
    end

    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic note(input logic [31:0] m, input logic [31:0] e);
        notes.push_back({m, e});
        -> look;
    endtask
    // One request pulse; the answer lands one cycle later.
    task automatic req(input logic wm, input csp_mode_t m, input csp_src_t s,
                       input logic [2:0] dv);
        mode_in = m;
        src_in = s;
        div_in = dv;
        mode_wr = wm;
        clk_wr = !wm;
        tick(1);
        mode_wr = 1'b0;
        clk_wr = 1'b0;
        tick(1);
    endtask
    // Expected selection; the refusal flag is cleared afterwards.
    task automatic sel(input csp_mode_t m, input csp_src_t s,
                       input logic [2:0] dv, input logic e);
        logic [1:0] v;
        v = (m == CSP_MODE_HIGH) ? 2'h2 : (m <= CSP_MODE_MID_B) ? 2'h1 : 2'h0;
        note(32'h0000ffe0, {16'h0000, m, s, dv, v, e, 5'h00});
        order_err_clr = 1'b1;
        tick(1);
        order_err_clr = 1'b0;
    endtask
    // Main oscillator halts past the detection time, then restarts.
    task automatic stall(input logic [15:0] e);
        // Non-blocking, so the model reads one settled value at this edge.
        main_run <= 1'b0;
        tick(OSD + 4);
        note(32'h0000fffc, {16'h0000, e});
        main_run <= 1'b1;
        tick(2);
        osd_clr = 1'b1;
        tick(1);
        osd_clr = 1'b0;
    endtask
    // Run windows until a fresh result under these limits is flagged.
    task automatic meas(input csp_src_t mon, input csp_ref_t r,
                        input logic [15:0] hi, input logic [15:0] lo,
                        input logic err, input logic [15:0] c);
        int k;
        mon_sel = mon;
        ref_sel = r;
        lim_hi = hi;
        lim_lo = lo;
        {meas_done_ie, range_err_ie} = 2'($random(seed));
        meas_en = 1'b1;
        repeat (2) begin
            meas_done_clr = 1'b1;
            range_err_clr = 1'b1;
            tick(1);
            meas_done_clr = 1'b0;
            range_err_clr = 1'b0;
            for (k = 0; k < 300 && meas_done_flag !== 1'b1; k++)
                tick(1);
        end
        note(32'hffff0003, {c, 14'h0000, 1'b1, err});
        meas_en = 1'b0;
        tick(2);
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard, far beyond the thousand or so cycles the tests need.
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    // Main sequence.
    initial begin
        tick(16);
        rstn = 1'b1;
        tick(1);
        sel(CSP_MODE_HIGH, SRC_LS, 3'h0, 1'b0);
        req(1'b0, CSP_MODE_HIGH, CSP_SRC_MAIN, 3'h0);
        sel(CSP_MODE_HIGH, CSP_SRC_MAIN, 3'h0, 1'b0);
        req(1'b1, CSP_MODE_MID_A, SRC_LS, 3'h0);
        req(1'b1, CSP_MODE_LOW_A, SRC_LS, 3'h0);
        sel(CSP_MODE_MID_A, CSP_SRC_MAIN, 3'h0, 1'b1);
        req(1'b0, CSP_MODE_HIGH, SRC_LS, 3'h0);
        req(1'b1, CSP_MODE_LOW_A, SRC_LS, 3'h0);
        sel(CSP_MODE_LOW_A, SRC_LS, 3'h0, 1'b0);
        req(1'b0, CSP_MODE_HIGH, CSP_SRC_MAIN, 3'h0);
        sel(CSP_MODE_LOW_A, SRC_LS, 3'h0, 1'b1);
        for (int m = 0; m < 6; m++) begin
            req(1'b1, csp_mode_t'(m), SRC_LS, 3'h0);
            sel(csp_mode_t'((m < 5) ? m : 4), SRC_LS, 3'h0,
                m == 5);
        end
        d = 3'($random(seed));
        req(1'b1, CSP_MODE_HIGH, SRC_LS, 3'h0);
        req(1'b0, CSP_MODE_HIGH, CSP_SRC_PLL, d);
        sel(CSP_MODE_HIGH, CSP_SRC_PLL, d, 1'b0);
        stall({CSP_MODE_HIGH, CSP_SRC_PLL, d, 2'h2, 4'h7, 2'h0});
        req(1'b0, CSP_MODE_HIGH, CSP_SRC_MAIN, 3'h0);
        stall({CSP_MODE_HIGH, SRC_LS, 3'h0, 2'h2, 4'h3, 2'h0});
        req(1'b0, CSP_MODE_HIGH, CSP_SRC_SUB, 3'h0);
        osd_ie = 1'b0;
        stall({CSP_MODE_HIGH, CSP_SRC_SUB, 3'h0, 2'h2, 4'h2, 2'h0});
        // With detection off a main stop neither flags nor falls back.
        req(1'b0, CSP_MODE_HIGH, CSP_SRC_MAIN, 3'h0);
        osd_en = 1'b0;
        stall({CSP_MODE_HIGH, CSP_SRC_MAIN, 3'h0, 2'h2, 4'h0,
               2'h0});
        osd_en = 1'b1;
        meas(CSP_SRC_MAIN, CSP_REF_EXT, 16'h0024, 16'h001c, 1'b0,
             16'h0020);
        meas(CSP_SRC_MAIN, CSP_REF_EXT, 16'($random(seed) & 15), 16'h0000,
             1'b1, 16'h0020);
        meas(CSP_SRC_MAIN, CSP_REF_EXT, 16'hffff, 16'h0028, 1'b1,
             16'h0020);
        meas(CSP_SRC_SUB, CSP_REF_INT, 16'h0005, 16'h0003, 1'b0,
             16'h0004);
        sub_run <= 1'b0;
        meas(CSP_SRC_SUB, CSP_REF_INT, 16'h0005, 16'h0003, 1'b1,
             16'h0000);
        complete_run();
    end
endmodule
